// File: hdl/pwmorc_pkg.sv
// Package of constants and types for the PWM output routing control block.
// Contract
// - Main pin enables gate PWM; reset high.
// - Clone enables of modules 0, 2 reset low.
// - Modules 0, 2 drive two maskable clones.
// - Per-channel inversion selects normal or complement.
// - Module pins 0-7: GPIO or PWM.
// - Break flag blocks channels 0-5 to GPIO.
// - Clock output toggles on each overflow: half overflow rate.
// - Clock pin select: P4.7 or P3.3.
// - Capture inputs 4, 2 from pin or timer.
// - Module 2 clones: P6.0/P6.1 or P3.4/P3.5.
// - Module 0 clones: P1.6/P1.7 or P6.0/P6.1.
// - Modules 0, 4 pin map select.
// - Modules 6, 7: P6.0/P6.1 or P3.0/P3.1.
// - Fixed-resolution center mode: 8/10/12/16 bits.
// - Variable resolution needs both mode bits set.
// - Variable center mode offers all compare modes.
// - Overflow flag at top or bottom select.
// - Center alignment on enabled channels, half frequency.
// - Break flag sticky; only software clears it.
package pwmorc_pkg;

  // ---------------------------------------------------------------------------
  // Sizes and pin indices
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CH  = 8;
  localparam int unsigned NUM_PIN = 15;
  localparam int unsigned NUM_SRC = 13;
  localparam logic [3:0] PIN_P1_6 = 4'h0;
  localparam logic [3:0] PIN_P1_7 = 4'h1;
  localparam logic [3:0] PIN_P2_2 = 4'h2;
  localparam logic [3:0] PIN_P2_4 = 4'h3;
  localparam logic [3:0] PIN_P3_0 = 4'h4;
  localparam logic [3:0] PIN_P3_1 = 4'h5;
  localparam logic [3:0] PIN_P3_3 = 4'h6;
  localparam logic [3:0] PIN_P3_4 = 4'h7;
  localparam logic [3:0] PIN_P3_5 = 4'h8;
  localparam logic [3:0] PIN_P4_7 = 4'h9;
  localparam logic [3:0] PIN_P6_0 = 4'ha;
  localparam logic [3:0] PIN_P6_1 = 4'hb;
  localparam logic [3:0] PIN_CEX1 = 4'hc;
  localparam logic [3:0] PIN_CEX3 = 4'hd;
  localparam logic [3:0] PIN_CEX5 = 4'he;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index) and pages
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_AUX    = 10'h0a4;
  localparam logic [9:0] IDX_PWM_PIN_OUTPUT_ENABLES   = 10'h0f1;
  localparam logic [9:0] IDX_BREAK  = 10'h0a1;
  localparam logic [9:0] IDX_MODE   = 10'h0bc;
  localparam logic [9:0] IDX_INVERT = 10'h0c0;
  localparam logic [9:0] IDX_ASSIGN = 10'h0c1;
  localparam logic [9:0] IDX_STATUS = 10'h0c2;
  localparam logic [9:0] IDX_PAGE   = 10'h0ff;
  localparam logic [7:0] PAGE_AUX5  = 8'h02;
  localparam logic [7:0] PAGE_AUX7  = 8'h04;
  localparam logic [7:0] PAGE_AUX8  = 8'h05;
  localparam logic [7:0] PAGE_AUX11 = 8'h08;

  // ---------------------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_PWM_PIN_OUTPUT_ENABLES  = 8'h99;
  localparam logic [7:0] RST_AUX7  = 8'hc0;
  localparam logic [7:0] RST_AUX8  = 8'hc0;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] MSK_AUX7  = 8'he0;
  localparam logic [7:0] MSK_AUX5  = 8'hf5;
  localparam logic [7:0] MSK_AUX8  = 8'he0;
  localparam logic [7:0] MSK_AUX11 = 8'h03;
  localparam logic [7:0] MSK_MODE  = 8'h83;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned B_POE0 = 0;
  localparam int unsigned B_CLONE_A_ENABLE_CH0 = 1;
  localparam int unsigned B_CLONE_B_ENABLE_CH0 = 2;
  localparam int unsigned B_POE1 = 3;
  localparam int unsigned B_POE2 = 4;
  localparam int unsigned B_CLONE_A_ENABLE_CH2 = 5;
  localparam int unsigned B_CLONE_B_ENABLE_CH2 = 6;
  localparam int unsigned B_POE3 = 7;
  localparam int unsigned B_POE4 = 6;
  localparam int unsigned B_POE5 = 7;
  localparam int unsigned B_CKOE = 5;
  localparam int unsigned B_IN4SEL = 7;
  localparam int unsigned B_IN2SEL = 6;
  localparam int unsigned B_CL2SEL = 5;
  localparam int unsigned B_CL0SEL = 4;
  localparam int unsigned B_MODSEL = 2;
  localparam int unsigned B_CKPSEL = 0;
  localparam int unsigned B_POE6 = 6;
  localparam int unsigned B_POE7 = 7;
  localparam int unsigned B_S67SEL = 5;
  localparam int unsigned B_VARRES = 1;
  localparam int unsigned B_OFSBOT = 0;
  localparam int unsigned B_CENTER = 7;
  localparam int unsigned B_BRK = 4;
  localparam int unsigned B_OVF = 0;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    PWMORC_SEL_NONE, PWMORC_SEL_PAGE, PWMORC_SEL_PWM_PIN_OUTPUT_ENABLES, PWMORC_SEL_AUX5,
    PWMORC_SEL_AUX7, PWMORC_SEL_AUX8, PWMORC_SEL_AUX11, PWMORC_SEL_BREAK,
    PWMORC_SEL_MODE, PWMORC_SEL_INVERT, PWMORC_SEL_ASSIGN, PWMORC_SEL_STATUS
  } pwmorc_sel_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] pwm_pin_output_enables;
    logic [7:0] aux5;
    logic [7:0] aux7;
    logic [7:0] aux8;
    logic [7:0] aux11;
    logic [7:0] mode;
    logic [7:0] invert;
    logic [7:0] assign_pwm;
  } pwmorc_cfg_t;

  typedef struct packed {
    logic       center_align;
    logic       var_res;
    logic       ovf_at_bottom;
    logic       all_modes;
    logic [1:0] res_code;
  } pwmorc_mode_t;

  localparam pwmorc_cfg_t CFG_RST = '{
    page: RST_ZERO, pwm_pin_output_enables: RST_PWM_PIN_OUTPUT_ENABLES, aux5: RST_ZERO, aux7: RST_AUX7, aux8: RST_AUX8,
    aux11: RST_ZERO, mode: RST_ZERO, invert: RST_ZERO, assign_pwm: RST_ZERO};
  localparam pwmorc_mode_t MODE_RST = '{
    center_align: 1'b0, var_res: 1'b0, ovf_at_bottom: 1'b0, all_modes: 1'b1,
    res_code: 2'h0};

endpackage

// File: hdl/pwmorc_top.sv
// Output stage, pin routing and mode control of the counter array PWM outputs.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module pwmorc_top
  import pwmorc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                sys_clk,                // System clock, 125 MHz.
  input  wire logic                nrst,                   // Asynchronous reset, active low.
  input  wire logic [ADDR_W-1:0]   paddr,                  // APB byte address.
  input  wire logic                psel,                   // APB select.
  input  wire logic                penable,                // APB enable.
  input  wire logic                pwrite,                 // APB direction, high for write.
  input  wire logic [31:0]         pwdata,                 // APB write data.
  input  wire logic [3:0]          pstrb,                  // APB byte strobes.
  output logic [31:0]              prdata,                 // APB read data.
  output logic                     pready,                 // APB ready.
  output logic                     pslverr,                // APB error, unmapped index.
  input  wire logic [NUM_CH-1:0]   main_pwm_output,        // Raw PWM waveforms of modules.
  input  wire logic                break_event,            // Break source pulse.
  input  wire logic                base_ovf,               // Base timer overflow pulse.
  input  wire logic                cycle_top,              // Center cycle top pulse.
  input  wire logic                cycle_bottom,           // Center cycle bottom pulse.
  input  wire logic [NUM_PIN-1:0]  gpio_latch,             // Port latch values per pin.
  input  wire logic [NUM_PIN-1:0]  pin_in,                 // Pin levels, asynchronous.
  input  wire logic                timer2_ext_input,       // Timer 2 external pin.
  input  wire logic                timer3_ext_input,       // Timer 3 external pin.
  output logic [NUM_PIN-1:0]       pin_out,                // Level presented to each pin.
  output logic [NUM_PIN-1:0]       pin_oe,                 // High while the array drives pin.
  output logic                     capture_in2,            // Capture input of module 2.
  output logic                     capture_in4,            // Capture input of module 4.
  output logic                     array_clock_out,        // Clock output level.
  output logic                     counter_overflow_flag,  // Sticky overflow flag.
  output logic                     break_flag,             // Sticky break flag.
  output pwmorc_mode_t             mode_out                // Mode towards the counter.
);

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  function automatic pwmorc_sel_t decode(input logic [ADDR_W-1:0] addr,
                                         input logic [7:0] page);
    logic [9:0] idx;
    idx = 10'(addr >> 2);
    if (addr[1:0] != 2'h0) begin
      decode = PWMORC_SEL_NONE;
    end else begin
      case (idx)
        IDX_PAGE:   decode = PWMORC_SEL_PAGE;
        IDX_PWM_PIN_OUTPUT_ENABLES:   decode = PWMORC_SEL_PWM_PIN_OUTPUT_ENABLES;
        IDX_BREAK:  decode = PWMORC_SEL_BREAK;
        IDX_MODE:   decode = PWMORC_SEL_MODE;
        IDX_INVERT: decode = PWMORC_SEL_INVERT;
        IDX_ASSIGN: decode = PWMORC_SEL_ASSIGN;
        IDX_STATUS: decode = PWMORC_SEL_STATUS;
        IDX_AUX: begin
          case (page)
            PAGE_AUX5:  decode = PWMORC_SEL_AUX5;
            PAGE_AUX7:  decode = PWMORC_SEL_AUX7;
            PAGE_AUX8:  decode = PWMORC_SEL_AUX8;
            PAGE_AUX11: decode = PWMORC_SEL_AUX11;
            default:    decode = PWMORC_SEL_NONE;
          endcase
        end
        default: decode = PWMORC_SEL_NONE;
      endcase
    end
  endfunction

  pwmorc_cfg_t   cfg;
  pwmorc_cfg_t   next_cfg;
  logic          next_break_flag;
  logic          next_counter_overflow_flag;
  logic          next_array_clock_out;
  logic [31:0]   next_prdata;
  logic          next_pready;
  logic          next_pslverr;
  logic          setup;
  logic          wr;
  pwmorc_sel_t   rd_sel;
  pwmorc_sel_t   wr_sel;
  logic [7:0]    wbyte;
  logic [7:0]    rbyte;
  logic          var_res_active;
  logic          ovf_event;

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready & pwrite & pstrb[0];
  assign wbyte  = pwdata[7:0];
  assign rd_sel = decode(paddr, cfg.page);
  assign wr_sel = decode(paddr, cfg.page);

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    if (wr) begin
      case (wr_sel)
        PWMORC_SEL_PAGE:   next_cfg.page = wbyte;
        PWMORC_SEL_PWM_PIN_OUTPUT_ENABLES:   next_cfg.pwm_pin_output_enables = wbyte;
        PWMORC_SEL_AUX5:   next_cfg.aux5 = wbyte & MSK_AUX5;
        PWMORC_SEL_AUX7:   next_cfg.aux7 = wbyte & MSK_AUX7;
        PWMORC_SEL_AUX8:   next_cfg.aux8 = wbyte & MSK_AUX8;
        PWMORC_SEL_AUX11:  next_cfg.aux11 = wbyte & MSK_AUX11;
        PWMORC_SEL_MODE:   next_cfg.mode = wbyte & MSK_MODE;
        PWMORC_SEL_INVERT: next_cfg.invert = wbyte;
        PWMORC_SEL_ASSIGN: next_cfg.assign_pwm = wbyte;
        default:           next_cfg = cfg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= CFG_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky flags and clock output
  // ---------------------------------------------------------------------------
  // Set takes priority over a software clear in the same cycle, so no event is lost.
  assign var_res_active = cfg.aux11[B_VARRES] & cfg.mode[B_CENTER];
  always_comb begin
    if (var_res_active) begin
      ovf_event = cfg.aux11[B_OFSBOT] ? cycle_bottom : cycle_top;
    end else begin
      ovf_event = base_ovf;
    end
    next_break_flag = break_flag;
    if (wr && wr_sel == PWMORC_SEL_BREAK) begin
      next_break_flag = wbyte[B_BRK];
    end
    if (break_event) begin
      next_break_flag = 1'b1;
    end
    next_counter_overflow_flag = counter_overflow_flag;
    if (wr && wr_sel == PWMORC_SEL_STATUS && !wbyte[B_OVF]) begin
      next_counter_overflow_flag = 1'b0;
    end
    if (ovf_event) begin
      next_counter_overflow_flag = 1'b1;
    end
    if (!cfg.aux7[B_CKOE]) begin
      next_array_clock_out = 1'b0;
    end else if (base_ovf) begin
      next_array_clock_out = ~array_clock_out;
    end else begin
      next_array_clock_out = array_clock_out;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      break_flag            <= 1'b0;
      counter_overflow_flag <= 1'b0;
      array_clock_out       <= 1'b0;
    end else begin
      break_flag            <= next_break_flag;
      counter_overflow_flag <= next_counter_overflow_flag;
      array_clock_out       <= next_array_clock_out;
    end
  end

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // Read data is captured in the setup cycle so every output stays a flip-flop;
  // the price is one access cycle per transfer.
  always_comb begin
    case (rd_sel)
      PWMORC_SEL_PAGE:   rbyte = cfg.page;
      PWMORC_SEL_PWM_PIN_OUTPUT_ENABLES:   rbyte = cfg.pwm_pin_output_enables;
      PWMORC_SEL_AUX5:   rbyte = cfg.aux5;
      PWMORC_SEL_AUX7:   rbyte = cfg.aux7;
      PWMORC_SEL_AUX8:   rbyte = cfg.aux8;
      PWMORC_SEL_AUX11:  rbyte = cfg.aux11;
      PWMORC_SEL_BREAK:  rbyte = {3'h0, break_flag, 4'h0};
      PWMORC_SEL_MODE:   rbyte = cfg.mode;
      PWMORC_SEL_INVERT: rbyte = cfg.invert;
      PWMORC_SEL_ASSIGN: rbyte = cfg.assign_pwm;
      PWMORC_SEL_STATUS: rbyte = {4'h0, break_flag, var_res_active, array_clock_out,
                                  counter_overflow_flag};
      default:           rbyte = 8'h00;
    endcase
    next_pready  = setup;
    next_pslverr = setup & (rd_sel == PWMORC_SEL_NONE);
    next_prdata  = (setup & ~pwrite) ? {24'h000000, rbyte} : 32'h00000000;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin inputs and capture routing
  // ---------------------------------------------------------------------------
  logic [NUM_PIN-1:0] pin_meta;
  logic [NUM_PIN-1:0] pin_sync;
  logic [1:0]         tex_meta;
  logic [1:0]         tex_sync;
  logic               next_capture_in2;
  logic               next_capture_in4;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      tex_meta <= 2'h0;
      tex_sync <= 2'h0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      tex_meta <= {timer3_ext_input, timer2_ext_input};
      tex_sync <= tex_meta;
    end
  end

  always_comb begin
    next_capture_in2 = cfg.aux5[B_IN2SEL] ? tex_sync[1] : pin_sync[PIN_P2_4];
    if (cfg.aux5[B_IN4SEL]) begin
      next_capture_in4 = tex_sync[0];
    end else begin
      next_capture_in4 = cfg.aux5[B_MODSEL] ? pin_sync[PIN_P3_1] : pin_sync[PIN_P1_7];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      capture_in2 <= 1'b0;
      capture_in4 <= 1'b0;
    end else begin
      capture_in2 <= next_capture_in2;
      capture_in4 <= next_capture_in4;
    end
  end

  // ---------------------------------------------------------------------------
  // Output stage and pin placement
  // ---------------------------------------------------------------------------
  // Sources are placed in list order, so a later source wins a pin shared by two.
  logic [NUM_CH-1:0]  wave;
  logic [NUM_CH-1:0]  main_en;
  logic [NUM_CH-1:0]  main_drv;
  logic [3:0]         src_pin [NUM_SRC];
  logic [NUM_SRC-1:0] src_drv;
  logic [NUM_SRC-1:0] src_val;
  logic [NUM_PIN-1:0] next_pin_out;
  logic [NUM_PIN-1:0] next_pin_oe;
  pwmorc_mode_t       next_mode_out;

  assign wave    = main_pwm_output ^ cfg.invert;
  assign main_en = {cfg.aux8[B_POE7], cfg.aux8[B_POE6], cfg.aux7[B_POE5], cfg.aux7[B_POE4],
                    cfg.pwm_pin_output_enables[B_POE3], cfg.pwm_pin_output_enables[B_POE2], cfg.pwm_pin_output_enables[B_POE1], cfg.pwm_pin_output_enables[B_POE0]};

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      main_drv[i] = cfg.assign_pwm[i] & main_en[i] & ~(break_flag & (i < 6));
    end
    src_pin[0]  = cfg.aux5[B_MODSEL] ? PIN_P3_0 : PIN_P2_2;
    src_pin[1]  = PIN_CEX1;
    src_pin[2]  = PIN_P2_4;
    src_pin[3]  = PIN_CEX3;
    src_pin[4]  = cfg.aux5[B_MODSEL] ? PIN_P3_1 : PIN_P1_7;
    src_pin[5]  = PIN_CEX5;
    src_pin[6]  = cfg.aux8[B_S67SEL] ? PIN_P3_0 : PIN_P6_0;
    src_pin[7]  = cfg.aux8[B_S67SEL] ? PIN_P3_1 : PIN_P6_1;
    src_pin[8]  = cfg.aux5[B_CL0SEL] ? PIN_P6_0 : PIN_P1_6;
    src_pin[9]  = cfg.aux5[B_CL0SEL] ? PIN_P6_1 : PIN_P1_7;
    src_pin[10] = cfg.aux5[B_CL2SEL] ? PIN_P3_4 : PIN_P6_0;
    src_pin[11] = cfg.aux5[B_CL2SEL] ? PIN_P3_5 : PIN_P6_1;
    src_pin[12] = cfg.aux5[B_CKPSEL] ? PIN_P3_3 : PIN_P4_7;
    src_drv[7:0] = main_drv;
    src_val[7:0] = wave;
    src_drv[8]  = cfg.pwm_pin_output_enables[B_CLONE_A_ENABLE_CH0] & ~break_flag;
    src_drv[9]  = cfg.pwm_pin_output_enables[B_CLONE_B_ENABLE_CH0] & ~break_flag;
    src_drv[10] = cfg.pwm_pin_output_enables[B_CLONE_A_ENABLE_CH2] & ~break_flag;
    src_drv[11] = cfg.pwm_pin_output_enables[B_CLONE_B_ENABLE_CH2] & ~break_flag;
    src_val[8]  = wave[0];
    src_val[9]  = wave[0];
    src_val[10] = wave[2];
    src_val[11] = wave[2];
    src_drv[12] = cfg.aux7[B_CKOE];
    src_val[12] = array_clock_out;
    next_pin_out = gpio_latch;
    next_pin_oe  = '0;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (src_drv[k]) begin
        next_pin_out[src_pin[k]] = src_val[k];
        next_pin_oe[src_pin[k]]  = 1'b1;
      end
    end
    next_mode_out.center_align  = cfg.mode[B_CENTER];
    next_mode_out.var_res       = var_res_active;
    next_mode_out.ovf_at_bottom = cfg.aux11[B_OFSBOT];
    next_mode_out.all_modes     = ~cfg.mode[B_CENTER] | var_res_active;
    next_mode_out.res_code      = cfg.mode[1:0];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_out  <= '0;
      pin_oe   <= '0;
      mode_out <= MODE_RST;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe   <= next_pin_oe;
      mode_out <= next_mode_out;
    end
  end

endmodule // pwmorc_top

`default_nettype wire

// File: verif/pwmorc_checker.sv
// Concurrent checks on the ports of the PWM output routing block.
`timescale 1ns/1ps
`default_nettype none
module pwmorc_checker
  import pwmorc_pkg::*;
(
  input wire logic               sys_clk,               // Clock.
  input wire logic               nrst,                  // Reset.
  input wire logic               psel,                  // Select.
  input wire logic               penable,               // Enable.
  input wire logic               pwrite,                // Direction.
  input wire logic               pready,                // Ready.
  input wire logic               break_event,           // Break pulse.
  input wire logic               base_ovf,              // Overflow pulse.
  input wire logic               cycle_top,             // Top pulse.
  input wire logic               cycle_bottom,          // Bottom pulse.
  input wire logic [NUM_PIN-1:0] gpio_latch,            // Port latches.
  input wire logic [NUM_PIN-1:0] pin_out,               // Pin levels.
  input wire logic [NUM_PIN-1:0] pin_oe,                // Pin enables.
  input wire logic               array_clock_out,       // Clock out.
  input wire logic               counter_overflow_flag, // Overflow flag.
  input wire logic               break_flag             // Break flag.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_break_sets: assert property (break_event |=> break_flag)
    else $error("break flag not set");
  a_break_sticky: assert property (break_flag && !(psel && pwrite) |=> break_flag)
    else $error("break flag cleared without software");
  // Only channels 6, 7 and the clock output may still own a pin in a break.
  a_break_blocks: assert property (break_flag && $past(break_flag) |->
    (pin_oe & 15'h718f) == 15'h0000)
    else $error("blocked channel still drives");
  a_gpio_revert: assert property
    (((pin_out ^ $past(gpio_latch)) & ~pin_oe) == 15'h0000)
    else $error("released pin not at port latch");
  a_clock_rise: assert property ($rose(array_clock_out) |-> $past(base_ovf))
    else $error("clock out rose without overflow");
  a_ovf_cause: assert property ($rose(counter_overflow_flag) |->
    $past(base_ovf || cycle_top || cycle_bottom))
    else $error("overflow flag set without event");

  c_break: cover property ($rose(break_flag));
  c_clock: cover property ($rose(array_clock_out));
  c_ovf: cover property ($rose(counter_overflow_flag));
endmodule // pwmorc_checker
`default_nettype wire

// File: verif/pwmorc_pad_model.sv
// Port pads with pull-ups standing behind the routed pins.
`timescale 1ns/1ps
`default_nettype none
module pwmorc_pad_model
  import pwmorc_pkg::*;
(
  input  wire logic [NUM_PIN-1:0] pin_out, // Driven levels.
  input  wire logic [NUM_PIN-1:0] pin_oe,  // Drive enables.
  output logic      [NUM_PIN-1:0] pin_in   // Pad levels.
);
  // A released pad is pulled up, so it never shows a stale driven level.
  assign pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule // pwmorc_pad_model
`default_nettype wire

// File: verif/tb_pwm_output_routing_control.sv
// Self-checking testbench of the PWM output routing block.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_output_routing_control;
  import pwmorc_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic t2 = 1'b0, t3 = 1'b0, er;
  logic [3:0] ev = 4'h0;
  logic [7:0] pwm = 8'h00, rd;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [14:0] gpio = 15'h0000;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, cap2, cap4, cko, cof, bkf;
  wire logic [14:0] pin_in, pin_out, pin_oe;
  wire pwmorc_mode_t mode;
  int n_fail = 0, total_checks = 0;

  pwmorc_top pwmorc_top_i (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_pwm_output(pwm), .break_event(ev[3]),
    .base_ovf(ev[2]), .cycle_top(ev[1]), .cycle_bottom(ev[0]), .gpio_latch(gpio),
    .pin_in(pin_in), .timer2_ext_input(t2), .timer3_ext_input(t3), .pin_out(pin_out),
    .pin_oe(pin_oe), .capture_in2(cap2), .capture_in4(cap4), .array_clock_out(cko),
    .counter_overflow_flag(cof), .break_flag(bkf), .mode_out(mode));
  pwmorc_pad_model pwmorc_pad_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  initial forever #4 sys_clk = ~sys_clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until the edge at which pready is seen high.
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic aux(input logic [7:0] pg, input logic [7:0] d, input logic w);
    apb(1'b1, IDX_PAGE, pg);
    apb(w, IDX_AUX, d);
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic pins(input logic [14:0] oe, input logic [14:0] out);
    settle;
    chk(pin_oe, oe);
    chk(pin_out, out);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 4'h0;
    settle;
  endtask

  task automatic t_reset;
    apb(1'b0, IDX_PWM_PIN_OUTPUT_ENABLES, 8'h00);
    chk(rd, 8'h99);
    aux(PAGE_AUX7, 8'h00, 1'b0);
    chk(rd, 8'hc0);
    aux(PAGE_AUX8, 8'h00, 1'b0);
    chk(rd, 8'hc0);
    apb(1'b0, 10'h000, 8'h00);
    chk(er, 1'b1);
    pins(15'h0000, 15'h0000);
    $display("reset test done");
  endtask

  task automatic t_main;
    @(posedge sys_clk);
    pwm <= 8'h05;
    apb(1'b1, IDX_ASSIGN, 8'hff);
    pins(15'h7c0e, 15'h000c);
    apb(1'b1, IDX_INVERT, 8'h01);
    pins(15'h7c0e, 15'h0008);
    apb(1'b1, IDX_PWM_PIN_OUTPUT_ENABLES, 8'h98);
    gpio <= 15'h7fff;
    pins(15'h7c0a, 15'h03fd);
    $display("main output test done");
  endtask

  task automatic t_clone;
    apb(1'b1, IDX_INVERT, 8'h00);
    apb(1'b1, IDX_PWM_PIN_OUTPUT_ENABLES, 8'hff);
    aux(PAGE_AUX5, 8'h24, 1'b1);
    pins(15'h7dbb, 15'h03df);
    apb(1'b1, IDX_PWM_PIN_OUTPUT_ENABLES, 8'hfb);
    pins(15'h7db9, 15'h03df);
    apb(1'b1, IDX_BREAK, 8'h10);
    pins(15'h0c00, 15'h73ff);
    apb(1'b0, IDX_STATUS, 8'h00);
    chk(rd[3], 1'b1);
    apb(1'b1, IDX_BREAK, 8'h00);
    pins(15'h7db9, 15'h03df);
    pulse(4'h8);
    chk(bkf, 1'b1);
    pins(15'h0c00, 15'h73ff);
    apb(1'b1, IDX_BREAK, 8'h00);
    $display("clone and break test done");
  endtask

  task automatic t_clock;
    aux(PAGE_AUX7, 8'he0, 1'b1);
    pulse(4'h4);
    chk(cko, 1'b1);
    chk({pin_oe[9], pin_out[9]}, 2'b11);
    pulse(4'h4);
    chk(cko, 1'b0);
    aux(PAGE_AUX5, 8'h25, 1'b1);
    pins(15'h7df9, 15'h039f);
    aux(PAGE_AUX7, 8'hc0, 1'b1);
    pulse(4'h4);
    chk(cko, 1'b0);
    $display("clock output test done");
  endtask

  task automatic t_var;
    aux(PAGE_AUX11, 8'h03, 1'b1);
    apb(1'b1, IDX_MODE, 8'h83);
    settle;
    chk(mode, 6'h3f);
    apb(1'b1, IDX_STATUS, 8'h00);
    pulse(4'h2);
    chk(cof, 1'b0);
    pulse(4'h1);
    chk(cof, 1'b1);
    aux(PAGE_AUX11, 8'h02, 1'b1);
    apb(1'b1, IDX_STATUS, 8'h00);
    pulse(4'h5);
    chk(cof, 1'b0);
    pulse(4'h2);
    chk(cof, 1'b1);
    apb(1'b1, IDX_MODE, 8'h03);
    settle;
    chk({mode.var_res, mode.all_modes}, 2'b01);
    aux(PAGE_AUX11, 8'h00, 1'b1);
    apb(1'b1, IDX_MODE, 8'h80);
    settle;
    chk({mode.center_align, mode.var_res, mode.all_modes}, 3'b100);
    $display("variable resolution test done");
  endtask

  task automatic t_cap;
    aux(PAGE_AUX5, 8'hc0, 1'b1);
    @(posedge sys_clk);
    t2 <= 1'b1;
    t3 <= 1'b0;
    pulse(4'h0);
    chk({cap4, cap2}, 2'b10);
    aux(PAGE_AUX5, 8'h00, 1'b1);
    pulse(4'h0);
    chk({cap4, cap2}, 2'b01);
    $display("capture select test done");
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_main;
    t_clone;
    t_clock;
    t_var;
    t_cap;
    wrap_up;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    wrap_up;
  end
endmodule // tb_pwm_output_routing_control

bind pwmorc_top pwmorc_checker pwmorc_checker_i (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .break_event(break_event), .base_ovf(base_ovf), .cycle_top(cycle_top),
  .cycle_bottom(cycle_bottom), .gpio_latch(gpio_latch), .pin_out(pin_out), .pin_oe(pin_oe),
  .array_clock_out(array_clock_out), .counter_overflow_flag(counter_overflow_flag),
  .break_flag(break_flag));
`default_nettype wire
